/* hdl/lot_defines.vh */
`ifndef LOT_DEFINES_VH
`define LOT_DEFINES_VH
// register byte offsets
`define LOT_OFF_CFG 4'h0
`define LOT_OFF_STAT 4'h4
`define LOT_OFF_TIM0 4'h8
`define LOT_OFF_TIM1 4'hC
// configuration fields
`define LOT_CFG_STR_LSB 0
`define LOT_CFG_PDT_BIT 2
`define LOT_CFG_WRLEV_BIT 3
`define LOT_CFG_CATRN_BIT 4
`define LOT_CFG_ZQCAL_BIT 5
`define LOT_CFG_RST 32'h0000_0000
`define LOT_CFG_MASK 32'h0000_003F
// timing fields
`define LOT_TIM0_ODTE_LSB 8
`define LOT_TIM0_CPDED_LSB 16
`define LOT_TIM1_BL_LSB 8
`define LOT_TIM0_MASK 32'h00FF_FFFF
`define LOT_TIM1_MASK 32'h0000_FFFF
`define LOT_RD_OFF_LEAD 8'h02
// status fields
`define LOT_ST_PD 0
`define LOT_ST_ACTPD 1
`define LOT_ST_SREF 2
`define LOT_ST_DPD 3
`define LOT_ST_RDACT 4
`define LOT_ST_TERMDQ 5
`define LOT_ST_TERMDQS 6
`define LOT_ST_RXON 7
`define LOT_ST_REFBLK 8
// default cycle counts
`define LOT_TODTD_DEF 8'h04
`define LOT_TODTE_DEF 8'h04
`define LOT_TCPDED_DEF 8'h02
`define LOT_RL_DEF 8'h0C
`define LOT_BL_DEF 8'h08
// read data for unmapped offsets
`define LOT_UNMAPPED 32'h0000_0000
`endif

/* hdl/lot_delay_count.v */
`timescale 1ns/10ps
// delays a level change by a programmable number of cycles
module lot_delay_count #(
  parameter W = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // level in and programmed delay
  input wire levelIn,
  input wire [W-1:0] delayCycles,
  // delayed level
  output reg levelOut
);
  reg [W-1:0] cnt_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= {W{1'b0}};
      levelOut <= 1'b0;
    end
    else if (levelIn == levelOut)
    begin
      cnt_reg <= {W{1'b0}};
    end
    else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= delayCycles)
    begin
      levelOut <= levelIn;
      cnt_reg <= {W{1'b0}};
    end
    else
    begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // lot_delay_count

/* hdl/lot_odt_pd_ctrl.v */
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`include "lot_defines.vh"
// Operation
// - termination follows ODT pin, no sampling
// - reads force termination off
// - nonzero strength and high pin enable
// - pd bit zero: off in power-down
// - pd bit set: pin control kept
// - self refresh disables termination, delayed
// - deep power-down disables termination
// - CA training: termination off
// - write leveling: strobe termination only
// - termination per write/read/cal/training/leveling
// - read window RL-2 to RL+BL/2
// - CKE low with CS_n high: power-down
// - receivers off after tCPDED expires
// - no refresh during power-down
// - CKE high with CS_n high exits
// - idle versus active power-down
module lot_odt_pd_ctrl #(
  parameter CW = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  input wire [3:0] avsByteEnable,
  output reg [31:0] avsReadData,
  output wire avsWaitRequest,
  // memory-side pins and decoded events
  input wire cke,
  input wire csN,
  input wire odtPin,
  input wire readCmd,
  input wire sremEntry,
  input wire sremExit,
  input wire dpdEntry,
  input wire anyRowOpen,
  // termination, receiver and refresh-block controls
  output wire termDq,
  output wire termDqs,
  output wire rxEnable,
  output wire refreshBlock
);
  reg [31:0] cfg_reg;
  reg [31:0] tim0_reg;
  reg [31:0] tim1_reg;
  reg ackPend_reg;
  reg ckePrev_reg;
  reg pd_reg;
  reg actPd_reg;
  reg sref_reg;
  reg dpd_reg;
  reg [CW-1:0] cpdedCnt_reg;
  reg rxOn_reg;
  reg [CW-1:0] rdCnt_reg;
  reg rdBusy_reg;
  reg rdWin_reg;
  wire [1:0] strength = cfg_reg[`LOT_CFG_STR_LSB+1:`LOT_CFG_STR_LSB];
  wire pdTermBit = cfg_reg[`LOT_CFG_PDT_BIT];
  wire wrLev = cfg_reg[`LOT_CFG_WRLEV_BIT];
  wire caTrain = cfg_reg[`LOT_CFG_CATRN_BIT];
  wire zqCal = cfg_reg[`LOT_CFG_ZQCAL_BIT];
  wire [CW-1:0] tOdtd = tim0_reg[CW-1:0];
  wire [CW-1:0] tOdte = tim0_reg[`LOT_TIM0_ODTE_LSB+CW-1:`LOT_TIM0_ODTE_LSB];
  wire [CW-1:0] tCpded = tim0_reg[`LOT_TIM0_CPDED_LSB+CW-1:`LOT_TIM0_CPDED_LSB];
  wire [CW-1:0] rl = tim1_reg[CW-1:0];
  wire [CW-1:0] bl = tim1_reg[`LOT_TIM1_BL_LSB+CW-1:`LOT_TIM1_BL_LSB];
  wire [CW-1:0] rdOff = rl - `LOT_RD_OFF_LEAD;
  wire [CW-1:0] rdOn = rl + {1'b0, bl[CW-1:1]};
  wire pdEnter = ckePrev_reg && !cke && csN;
  wire pdLeave = pd_reg && cke && csN;
  wire dpdCmd = ckePrev_reg && !cke && dpdEntry;
  wire pdGateReq = pd_reg && !pdTermBit;
  wire srGateReq = sref_reg;
  wire dpdGateReq = dpd_reg;
  wire pdGate;
  wire srGate;
  wire dpdGate;
  wire modeOn = (strength != 2'b00);
  wire gateOff = pdGate || srGate || dpdGate || rdWin_reg || caTrain || zqCal;
  // pin level passes straight through, no clock sample
  wire pinTerm = modeOn && odtPin && !gateOff;

  assign termDq = pinTerm && !wrLev;
  assign termDqs = pinTerm;
  assign rxEnable = rxOn_reg;
  assign refreshBlock = pd_reg;
  assign avsWaitRequest = (avsRead || avsWrite) && !ackPend_reg;

  // delayed disables, separate for each mode
  lot_delay_count #(.W(CW)) uPdGate (
    .clk(clk),
    .rst_n(rst_n),
    .levelIn(pdGateReq),
    .delayCycles(pdGateReq ? tOdtd : tOdte),
    .levelOut(pdGate)
  );
  lot_delay_count #(.W(CW)) uSrGate (
    .clk(clk),
    .rst_n(rst_n),
    .levelIn(srGateReq),
    .delayCycles(srGateReq ? tOdtd : tOdte),
    .levelOut(srGate)
  );
  lot_delay_count #(.W(CW)) uDpdGate (
    .clk(clk),
    .rst_n(rst_n),
    .levelIn(dpdGateReq),
    .delayCycles(tOdtd),
    .levelOut(dpdGate)
  );

  // register bus: one wait cycle per access
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ackPend_reg <= 1'b0;
      cfg_reg <= `LOT_CFG_RST;
      tim0_reg <= {8'h00, `LOT_TCPDED_DEF, `LOT_TODTE_DEF, `LOT_TODTD_DEF};
      tim1_reg <= {16'h0000, `LOT_BL_DEF, `LOT_RL_DEF};
      avsReadData <= 32'h0000_0000;
    end
    else
    begin
      ackPend_reg <= (avsRead || avsWrite) && !ackPend_reg;
      if (avsWrite && ackPend_reg)
      begin
        case (avsAddress)
          `LOT_OFF_CFG: cfg_reg <= avsWriteData & `LOT_CFG_MASK;
          `LOT_OFF_TIM0: tim0_reg <= avsWriteData & `LOT_TIM0_MASK;
          `LOT_OFF_TIM1: tim1_reg <= avsWriteData & `LOT_TIM1_MASK;
          default: cfg_reg <= cfg_reg;
        endcase
      end
      if (avsRead && !ackPend_reg)
      begin
        case (avsAddress)
          `LOT_OFF_CFG: avsReadData <= cfg_reg;
          `LOT_OFF_STAT: avsReadData <= {23'h0, refreshBlock, rxOn_reg, termDqs,
            termDq, rdWin_reg, dpd_reg, sref_reg, actPd_reg, pd_reg};
          `LOT_OFF_TIM0: avsReadData <= tim0_reg;
          `LOT_OFF_TIM1: avsReadData <= tim1_reg;
          default: avsReadData <= `LOT_UNMAPPED;
        endcase
      end
    end
  end

  // power states and receiver gating
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ckePrev_reg <= 1'b1;
      pd_reg <= 1'b0;
      actPd_reg <= 1'b0;
      sref_reg <= 1'b0;
      dpd_reg <= 1'b0;
      cpdedCnt_reg <= {CW{1'b0}};
      rxOn_reg <= 1'b1;
    end
    else
    begin
      ckePrev_reg <= cke;
      if (pdEnter && !sremEntry)
      begin
        pd_reg <= 1'b1;
        actPd_reg <= anyRowOpen;
      end
      else if (pdLeave)
      begin
        pd_reg <= 1'b0;
        actPd_reg <= 1'b0;
      end
      if (ckePrev_reg && !cke && sremEntry)
        sref_reg <= 1'b1;
      else if (sremExit || (sref_reg && cke))
        sref_reg <= 1'b0;
      if (dpdCmd)
        dpd_reg <= 1'b1;
      else if (dpd_reg && cke)
        dpd_reg <= 1'b0;
      if (cke)
      begin
        cpdedCnt_reg <= {CW{1'b0}};
        rxOn_reg <= 1'b1;
      end
      else if (cpdedCnt_reg >= tCpded)
        rxOn_reg <= 1'b0;
      else
        cpdedCnt_reg <= cpdedCnt_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // read window from RL-2 to RL+BL/2 after the command
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdCnt_reg <= {CW{1'b0}};
      rdBusy_reg <= 1'b0;
      rdWin_reg <= 1'b0;
    end
    else if (readCmd)
    begin
      rdCnt_reg <= {CW{1'b0}};
      rdBusy_reg <= 1'b1;
      rdWin_reg <= rdWin_reg || (rdOff == {CW{1'b0}});
    end
    else if (rdBusy_reg)
    begin
      rdCnt_reg <= rdCnt_reg + {{(CW-1){1'b0}}, 1'b1};
      if (rdCnt_reg + {{(CW-1){1'b0}}, 1'b1} == rdOff)
        rdWin_reg <= 1'b1;
      if (rdCnt_reg + {{(CW-1){1'b0}}, 1'b1} == rdOn)
      begin
        rdWin_reg <= 1'b0;
        rdBusy_reg <= 1'b0;
      end
    end
  end
endmodule // lot_odt_pd_ctrl

/* tb/lot_checker.sv */
`timescale 1ns/10ps
module lot_checker (
  // clock and bus
  input wire clk, rst_n, avsWrite, avsWaitRequest,
  input wire [3:0] avsAddress,
  input wire [31:0] avsWriteData,
  // pins and outputs
  input wire cke, csN, odtPin, readCmd, sremEntry, dpdEntry,
  input wire termDq, termDqs, rxEnable, refreshBlock
);
  logic [5:0] cfgShadow_reg;
  wire offNow = !termDq && !termDqs;
  // shadow of the configuration word
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) cfgShadow_reg <= 6'h00;
    else if (avsWrite && !avsWaitRequest && avsAddress == 4'h0)
      cfgShadow_reg <= avsWriteData[5:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  str_zero_off_a: assert property (cfgShadow_reg[1:0] == 2'h0 |-> offNow)
    else $error("termination with zero strength");
  pin_low_off_a: assert property (!odtPin |-> offNow)
    else $error("termination with pin low");
  catrn_off_a: assert property (cfgShadow_reg[4] |-> offNow)
    else $error("termination in CA training");
  zqcal_off_a: assert property (cfgShadow_reg[5] |-> offNow)
    else $error("termination in calibration");
  wrlev_dq_a: assert property (cfgShadow_reg[3] |-> !termDq)
    else $error("dq termination in leveling");
  read_off_a: assert property (readCmd |-> ##11 offNow [*4])
    else $error("termination inside read window");
  rx_hold_a: assert property ($fell(cke) && csN |=> rxEnable)
    else $error("receivers off too early");
  rx_drop_a: assert property ($fell(cke) && csN ##1 !cke [*3] |=> !rxEnable)
    else $error("receivers still on");
  pd_gate_a: assert property ($fell(cke) && csN && !cfgShadow_reg[2] ##1 !cke [*6]
    |-> offNow)
    else $error("termination kept in power-down");
  pd_keep_a: assert property (!cke && $past(cke) == 1'b0 && cfgShadow_reg[2] && odtPin
    && cfgShadow_reg[1:0] != 2'h0 && cfgShadow_reg[5:3] == 3'h0 && !sremEntry
    && !dpdEntry |-> termDq && termDqs)
    else $error("termination lost in power-down");
  no_refresh_a: assert property (cke && $past(cke) |-> !refreshBlock)
    else $error("power-down flag outside power-down");
  cover property (readCmd);
  cover property ($fell(cke) && csN);
  cover property (cfgShadow_reg[3] && termDqs);
endmodule // lot_checker

bind lot_odt_pd_ctrl lot_checker lotChk (.clk, .rst_n, .avsWrite, .avsWaitRequest,
  .avsAddress, .avsWriteData, .cke, .csN, .odtPin, .readCmd, .sremEntry, .dpdEntry,
  .termDq, .termDqs, .rxEnable, .refreshBlock);

/* tb/lot_ctrl_model.sv */
`timescale 1ns/10ps
module lot_ctrl_model #(
  parameter int TCKE = 3
) (
  // clock and requests
  input wire clk, rst_n, odtReq, wlMode,
  input wire [1:0] lowMode,
  // pins and decoded events
  output logic cke, csN, odtPin, sremEntry, sremExit, dpdEntry
);
  logic [3:0] hold_reg;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {cke, csN, odtPin, sremEntry, sremExit, dpdEntry} <= 6'h30;
      hold_reg <= 4'h0;
    end
    else
    begin
      odtPin <= odtReq || wlMode;
      sremExit <= 1'b0;
      csN <= 1'b1;
      // cke level held for its minimum both ways
      if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
      // cke only moves once hold_reg is zero and lowMode asks for the other level; no write bursts driven
      else if (cke == (lowMode != 2'h0))
      begin
        cke <= !cke;
        hold_reg <= 4'(TCKE);
        csN <= !(cke && lowMode == 2'h3);
        sremEntry <= cke && lowMode == 2'h2;
        dpdEntry <= cke && lowMode == 2'h3;
        sremExit <= !cke && sremEntry;
      end
    end
endmodule // lot_ctrl_model

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, readCmd = 1'b0;
  logic anyRowOpen = 1'b0, odtReq = 1'b0, wlMode = 1'b0;
  logic [1:0] lowMode = 2'h0;
  logic [3:0] avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0, rd;
  wire [31:0] avsReadData;
  wire avsWaitRequest, cke, csN, odtPin, sremEntry, sremExit, dpdEntry;
  wire termDq, termDqs, rxEnable, refreshBlock;
  wire [1:0] term = {termDq, termDqs};
  int miscompares = 0, tests_run = 0, cycles = 0;
  // cfg[5:0], pin, expected dq and dqs
  logic [8:0] rows [7] = '{9'h004, 9'h00F, 9'h010, 9'h01F, 9'h04D, 9'h08C, 9'h10C};
  always #4 clk = !clk;
  lot_ctrl_model partner (.clk, .rst_n, .odtReq, .wlMode, .lowMode, .cke, .csN, .odtPin,
    .sremEntry, .sremExit, .dpdEntry);
  lot_odt_pd_ctrl uut (.clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable(4'hF), .avsReadData, .avsWaitRequest, .cke, .csN, .odtPin, .readCmd,
    .sremEntry, .sremExit, .dpdEntry, .anyRowOpen, .termDq, .termDqs, .rxEnable,
    .refreshBlock);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  // enter a low-power mode, check, then leave it unless deep power-down
  task automatic low(input logic [1:0] m, tIn, tOut, st);
    lowMode <= m;
    repeat (10) @(posedge clk);
    chk(32'(term), 32'(tIn));
    if (st != 2'h0)
    begin
      bus(1'b0, 4'h4, 32'h0);
      chk(32'(rd[1:0]), 32'(st));
      chk(32'({rxEnable, refreshBlock}), 32'h1);
    end
    lowMode <= (m == 2'h3) ? m : 2'h0;
    repeat (10) @(posedge clk);
    chk(32'(term), 32'(tOut));
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({term, rxEnable, refreshBlock}), 32'h2);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'h1, 32'hFFFFFFFF);
    bus(1'b0, 4'h1, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, 4'h0, 32'(rows[i][8:3]));
      wlMode <= rows[i][6];
      odtReq <= rows[i][2];
      repeat (2) @(posedge clk);
      chk(32'(term), 32'(rows[i][1:0]));
    end
    $display("table done");
    bus(1'b1, 4'h0, 32'h1);
    readCmd <= 1'b1;
    @(posedge clk);
    readCmd <= 1'b0;
    repeat (11) @(posedge clk);
    chk(32'(term), 32'h0);
    repeat (10) @(posedge clk);
    chk(32'(term), 32'h3);
    $display("read done");
    anyRowOpen <= 1'b1;
    low(2'h1, 2'h0, 2'h3, 2'h3);
    anyRowOpen <= 1'b0;
    bus(1'b1, 4'h0, 32'h5);
    low(2'h1, 2'h3, 2'h3, 2'h1);
    low(2'h2, 2'h0, 2'h3, 2'h0);
    low(2'h3, 2'h0, 2'h0, 2'h0);
    $display("power-down done");
    report_and_stop();
  end
endmodule // tb_top
